/* frst_pkg.sv */
package frst_pkg;
  // Clock and time base
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned CLK_NS        = 20;
  localparam int unsigned UNIT0_MS      = 10;
  localparam int unsigned UNIT1_MS      = 100;
  localparam int unsigned UNIT2_MS      = 1000;
  localparam int unsigned UNIT0_CYC     = CLK_HZ / 1000 * UNIT0_MS;
  localparam int unsigned UNIT1_CYC     = CLK_HZ / 1000 * UNIT1_MS;
  localparam int unsigned UNIT2_CYC     = CLK_HZ / 1000 * UNIT2_MS;
  // Trip-free run time after which the retry budget is restored
  localparam int unsigned CLEAN_RUN_S   = 10;
  localparam int unsigned CLEAN_RUN_CYC = CLK_HZ * CLEAN_RUN_S;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_RETRY  = 5'h04;
  localparam logic [4:0] OFS_ACCEL  = 5'h08;
  localparam logic [4:0] OFS_DECEL  = 5'h0c;
  localparam logic [4:0] OFS_MAXF   = 5'h10;
  localparam logic [4:0] OFS_FREF   = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;

  // Field positions
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned CTRL_SRC_LSB     = 1;
  localparam int unsigned CTRL_RAMP_BIT    = 4;
  localparam int unsigned CTRL_TSCALE_LSB  = 5;
  localparam int unsigned CTRL_SS_LSB      = 8;
  localparam int unsigned RETRY_CNT_LSB    = 0;
  localparam int unsigned RETRY_DLY_LSB    = 16;
  localparam int unsigned STAT_STATE_LSB   = 0;
  localparam int unsigned STAT_LEFT_LSB    = 4;
  localparam int unsigned STAT_FREQ_LSB    = 16;
  localparam int unsigned SS_RESTART_BIT   = 2;

  // Encodings
  localparam logic [2:0] SRC_TERM_ONE = 3'h1;
  localparam logic [2:0] SRC_TERM_TWO = 3'h2;
  localparam logic [1:0] TS_10MS      = 2'h0;
  localparam logic [1:0] TS_100MS     = 2'h1;

  // Reset values
  localparam logic [2:0]  RST_SRC       = 3'h1;
  localparam logic [1:0]  RST_TSCALE    = 2'h1;
  localparam logic [3:0]  RST_RETRY_CNT = 4'h0;
  localparam logic [15:0] RST_RETRY_DLY = 16'h000a;
  localparam logic [15:0] RST_ACCEL     = 16'h00c8;
  localparam logic [15:0] RST_DECEL     = 16'h012c;
  localparam logic [15:0] RST_MAXF      = 16'h1770;

  // Software settings
  typedef struct packed {
    logic        restart_after_reset_enable;
    logic [2:0]  command_source_select;
    logic        ramp_reference_select;
    logic [1:0]  time_scale_select;
    logic [7:0]  speed_search_options;
    logic [3:0]  retry_count_setting;
    logic [15:0] retry_delay_setting;
    logic [15:0] accel_time_setting;
    logic [15:0] decel_time_setting;
    logic [15:0] maximum_frequency_setting;
    logic [15:0] freq_ref;
  } frst_cfg_t;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_TRIP, ST_DELAY, ST_SEARCH} frst_state_t;
endpackage

/* frst_timer.sv */
`timescale 1ns/100ps
module frst_timer #(
  parameter int unsigned W = 48
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] val_i,
  input  wire logic         en_i,
  output logic              done_o
);
  logic [W-1:0] cnt_q;

  // Down counter, load has priority
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      cnt_q <= '0;
    else if (load_i)
      cnt_q <= val_i;
    else if (en_i && cnt_q != '0)
      cnt_q <= cnt_q - W'(1);
  end

  assign done_o = (cnt_q == '0);
endmodule

/* frst_ramp.sv */
`timescale 1ns/100ps
module frst_ramp (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        delta_i,
  input  wire logic [15:0] maxf_i,
  input  wire logic [47:0] acc_cyc_i,
  input  wire logic [47:0] dec_cyc_i,
  input  wire logic [15:0] target_i,
  input  wire logic        load_i,
  input  wire logic [15:0] load_val_i,
  output logic      [15:0] freq_o
);
  logic [15:0] tgt_q;
  logic [15:0] dspan_q;
  logic [47:0] acc_q;
  logic        up;
  logic [47:0] period;
  logic [15:0] span;
  logic [47:0] acc_n;

  // Span per ramp time: full scale or the step just requested
  assign up     = target_i > freq_o;
  assign period = up ? acc_cyc_i : dec_cyc_i;
  assign span   = delta_i ? dspan_q : maxf_i;
  assign acc_n  = acc_q + 48'(span);

  // Rate accumulator, one 0.01 Hz step when it wraps the period
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      freq_o  <= '0;
      tgt_q   <= '0;
      dspan_q <= '0;
      acc_q   <= '0;
    end
    else if (load_i)
    begin
      freq_o  <= load_val_i;
      tgt_q   <= target_i;
      dspan_q <= (target_i > load_val_i) ? target_i - load_val_i : load_val_i - target_i;
      acc_q   <= '0;
    end
    else if (target_i != tgt_q)
    begin
      tgt_q   <= target_i;
      dspan_q <= up ? target_i - freq_o : freq_o - target_i;
      acc_q   <= '0;
    end
    else if (target_i == freq_o)
      acc_q <= '0;
    else if (period == '0)
      freq_o <= target_i;
    else if (acc_n >= period)
    begin
      acc_q  <= acc_n - period;
      freq_o <= up ? freq_o + 16'h0001 : freq_o - 16'h0001;
    end
    else
      acc_q <= acc_n;
  end

  a_ramp_single_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !load_i && period != '0 |=> (freq_o - $past(freq_o) <= 16'h0001
      || $past(freq_o) - freq_o <= 16'h0001))
    else $error("Ramp moved more than one step");
  a_ramp_no_overshoot: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !load_i && target_i == tgt_q && up |=> freq_o <= $past(target_i))
    else $error("Ramp passed its target");
endmodule

/* frst_ctrl.sv */
// Summary of operation
// - Restart-after-reset set to 1 resumes after fault reset; 0, the default, does not.
// - Wait the retry delay, 0 to 60.0 s, default 1.0 s, before restarting.
// - Retry counter loads from setting 0..10, decrements per restart, stops at 0.
// - After a restart, no further restart until a new trip occurs.
// - Counter reloads to the setting after trip-free running for a set time.
// - Auto restart only with command source 1 or 2 (terminal modes).
// - Speed search option bit 2 makes a restarted run begin with a search.
// - Without speed search, restart from zero with the normal pattern.
// - Ramp reference 0 uses maximum frequency, 1 uses frequency change.
// - Accel time is 0 Hz to maximum frequency, range 0.0 to 600.0 s.
// - Decel time is maximum frequency down to 0 Hz.
// - Maximum mode rate is independent of target; time scales with target share.
// - Time scale 0, 1, 2 selects 0.01 s, 0.1 s, 1 s units.
// - Time scale applies to every time setting, including the retry delay.
// - Frequency-change mode ramp time covers present to next reference.
// - Changing time scale keeps the raw count, rescaling the time.
`timescale 1ns/100ps
module frst_ctrl #(
  parameter int unsigned UNIT0_CYC     = frst_pkg::UNIT0_CYC,
  parameter int unsigned UNIT1_CYC     = frst_pkg::UNIT1_CYC,
  parameter int unsigned UNIT2_CYC     = frst_pkg::UNIT2_CYC,
  parameter int unsigned CLEAN_RUN_CYC = frst_pkg::CLEAN_RUN_CYC
) (
  input  wire logic        MCLK_I,
  input  wire logic        RSTN_I,
  input  wire logic [4:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        RUN_CMD_I,
  input  wire logic        TRIP_I,
  input  wire logic        TRIP_RESET_I,
  input  wire logic        SEARCH_DONE_I,
  input  wire logic [15:0] SEARCH_FREQ_I,
  output logic             RUN_O,
  output logic             SPEED_SEARCH_O,
  output logic      [15:0] FREQ_O
);
  frst_pkg::frst_cfg_t   cfg_q;
  frst_pkg::frst_state_t state_q;
  logic [3:0]  retry_left_q;
  logic        armed_q;
  logic        run_prev_q;
  logic        bus_ack;
  logic        wr_go;
  logic [31:0] bmask;
  logic [31:0] cur_word;
  logic [31:0] new_word;
  logic [31:0] unit_cyc;
  logic [47:0] dly_cyc;
  logic [47:0] acc_cyc;
  logic [47:0] dec_cyc;
  logic [15:0] target;
  logic [15:0] ramp_freq;
  logic        ramp_load;
  logic [15:0] ramp_load_val;
  logic        dly_load;
  logic        dly_done;
  logic        clean_done;
  logic        src_term;
  logic        auto_ok;
  logic        run_rise;
  logic        dly_exit;

  // Bus handshake: one wait state, then waitrequest low for one cycle
  assign bus_ack = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
  assign wr_go   = AVS_WRITE_I && !AVS_WAITREQUEST_O;

  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      AVS_WAITREQUEST_O <= 1'b1;
    else
      AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
  end

  // Register image for reads and for merging byte writes
  always_comb
  begin
    cur_word = '0;
    case (AVS_ADDRESS_I)
      frst_pkg::OFS_CTRL:
      begin
        cur_word[frst_pkg::CTRL_RESTART_BIT]        = cfg_q.restart_after_reset_enable;
        cur_word[frst_pkg::CTRL_SRC_LSB +: 3]       = cfg_q.command_source_select;
        cur_word[frst_pkg::CTRL_RAMP_BIT]           = cfg_q.ramp_reference_select;
        cur_word[frst_pkg::CTRL_TSCALE_LSB +: 2]    = cfg_q.time_scale_select;
        cur_word[frst_pkg::CTRL_SS_LSB +: 8]        = cfg_q.speed_search_options;
      end
      frst_pkg::OFS_RETRY:
      begin
        cur_word[frst_pkg::RETRY_CNT_LSB +: 4]  = cfg_q.retry_count_setting;
        cur_word[frst_pkg::RETRY_DLY_LSB +: 16] = cfg_q.retry_delay_setting;
      end
      frst_pkg::OFS_ACCEL:
        cur_word[15:0] = cfg_q.accel_time_setting;
      frst_pkg::OFS_DECEL:
        cur_word[15:0] = cfg_q.decel_time_setting;
      frst_pkg::OFS_MAXF:
        cur_word[15:0] = cfg_q.maximum_frequency_setting;
      frst_pkg::OFS_FREF:
        cur_word[15:0] = cfg_q.freq_ref;
      frst_pkg::OFS_STATUS:
      begin
        cur_word[frst_pkg::STAT_STATE_LSB +: 3] = state_q;
        cur_word[frst_pkg::STAT_LEFT_LSB +: 4]  = retry_left_q;
        cur_word[frst_pkg::STAT_FREQ_LSB +: 16] = ramp_freq;
      end
      default:
        cur_word = '0;
    endcase
  end

  assign bmask    = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                     {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign new_word = (cur_word & ~bmask) | (AVS_WRITEDATA_I & bmask);

  // Read data captured as waitrequest drops
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      AVS_READDATA_O <= '0;
    else if (AVS_READ_I && AVS_WAITREQUEST_O)
      AVS_READDATA_O <= cur_word;
  end

  // Settings written by software; raw counts kept across scale changes
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      cfg_q                            <= '0;
      cfg_q.command_source_select      <= frst_pkg::RST_SRC;
      cfg_q.time_scale_select          <= frst_pkg::RST_TSCALE;
      cfg_q.retry_count_setting        <= frst_pkg::RST_RETRY_CNT;
      cfg_q.retry_delay_setting        <= frst_pkg::RST_RETRY_DLY;
      cfg_q.accel_time_setting         <= frst_pkg::RST_ACCEL;
      cfg_q.decel_time_setting         <= frst_pkg::RST_DECEL;
      cfg_q.maximum_frequency_setting  <= frst_pkg::RST_MAXF;
    end
    else if (wr_go)
    begin
      case (AVS_ADDRESS_I)
        frst_pkg::OFS_CTRL:
        begin
          cfg_q.restart_after_reset_enable <= new_word[frst_pkg::CTRL_RESTART_BIT];
          cfg_q.command_source_select      <= new_word[frst_pkg::CTRL_SRC_LSB +: 3];
          cfg_q.ramp_reference_select      <= new_word[frst_pkg::CTRL_RAMP_BIT];
          cfg_q.time_scale_select          <= new_word[frst_pkg::CTRL_TSCALE_LSB +: 2];
          cfg_q.speed_search_options       <= new_word[frst_pkg::CTRL_SS_LSB +: 8];
        end
        frst_pkg::OFS_RETRY:
        begin
          cfg_q.retry_count_setting <= new_word[frst_pkg::RETRY_CNT_LSB +: 4];
          cfg_q.retry_delay_setting <= new_word[frst_pkg::RETRY_DLY_LSB +: 16];
        end
        frst_pkg::OFS_ACCEL:
          cfg_q.accel_time_setting <= new_word[15:0];
        frst_pkg::OFS_DECEL:
          cfg_q.decel_time_setting <= new_word[15:0];
        frst_pkg::OFS_MAXF:
          cfg_q.maximum_frequency_setting <= new_word[15:0];
        frst_pkg::OFS_FREF:
          cfg_q.freq_ref <= new_word[15:0];
        default:
          cfg_q <= cfg_q;
      endcase
    end
  end

  // Time unit per scale; every time setting is raw count times unit
  always_comb
  begin
    case (cfg_q.time_scale_select)
      frst_pkg::TS_10MS:  unit_cyc = UNIT0_CYC;
      frst_pkg::TS_100MS: unit_cyc = UNIT1_CYC;
      default:            unit_cyc = UNIT2_CYC;
    endcase
  end

  assign dly_cyc = 48'(cfg_q.retry_delay_setting) * 48'(unit_cyc);
  assign acc_cyc = 48'(cfg_q.accel_time_setting) * 48'(unit_cyc);
  assign dec_cyc = 48'(cfg_q.decel_time_setting) * 48'(unit_cyc);

  // Restart qualification
  assign src_term = cfg_q.command_source_select == frst_pkg::SRC_TERM_ONE
                 || cfg_q.command_source_select == frst_pkg::SRC_TERM_TWO;
  assign auto_ok  = cfg_q.restart_after_reset_enable && src_term
                 && retry_left_q != 4'h0 && armed_q;
  assign run_rise = RUN_CMD_I && !run_prev_q;
  assign dly_exit = state_q == frst_pkg::ST_DELAY && dly_done && !TRIP_I;

  // Run command edge history
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      run_prev_q <= 1'b0;
    else
      run_prev_q <= RUN_CMD_I;
  end

  // Operating sequence
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      state_q <= frst_pkg::ST_IDLE;
    else if (TRIP_I)
      state_q <= frst_pkg::ST_TRIP;
    else
    begin
      case (state_q)
        frst_pkg::ST_IDLE:
          if (run_rise)
            state_q <= frst_pkg::ST_RUN;
        frst_pkg::ST_RUN:
          if (!RUN_CMD_I && ramp_freq == 16'h0000)
            state_q <= frst_pkg::ST_IDLE;
        frst_pkg::ST_TRIP:
          if (TRIP_RESET_I)
            state_q <= auto_ok ? frst_pkg::ST_DELAY : frst_pkg::ST_IDLE;
        frst_pkg::ST_DELAY:
          if (dly_done)
          begin
            if (!RUN_CMD_I)
              state_q <= frst_pkg::ST_IDLE;
            else if (cfg_q.speed_search_options[frst_pkg::SS_RESTART_BIT])
              state_q <= frst_pkg::ST_SEARCH;
            else
              state_q <= frst_pkg::ST_RUN;
          end
        frst_pkg::ST_SEARCH:
          if (SEARCH_DONE_I)
            state_q <= frst_pkg::ST_RUN;
        default:
          state_q <= frst_pkg::ST_IDLE;
      endcase
    end
  end

  // One restart per trip: armed by a trip, spent by a restart
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      armed_q <= 1'b0;
    else if (TRIP_I)
      armed_q <= 1'b1;
    else if (dly_exit && RUN_CMD_I)
      armed_q <= 1'b0;
  end

  // Retry budget: decrement per restart, restore after clean running
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      retry_left_q <= frst_pkg::RST_RETRY_CNT;
    else if (wr_go && AVS_ADDRESS_I == frst_pkg::OFS_RETRY)
      retry_left_q <= new_word[frst_pkg::RETRY_CNT_LSB +: 4];
    else if (dly_exit && RUN_CMD_I && retry_left_q != 4'h0)
      retry_left_q <= retry_left_q - 4'h1;
    else if (state_q == frst_pkg::ST_RUN && clean_done)
      retry_left_q <= cfg_q.retry_count_setting;
  end

  // Retry delay timer
  assign dly_load = state_q == frst_pkg::ST_TRIP && TRIP_RESET_I && !TRIP_I;

  frst_timer #(
    .W (48)
  ) u_dly (
    .clk_i  (MCLK_I),
    .rstn_i (RSTN_I),
    .load_i (dly_load),
    .val_i  (dly_cyc),
    .en_i   (state_q == frst_pkg::ST_DELAY),
    .done_o (dly_done)
  );

  // Trip-free running timer, rearmed outside normal running
  frst_timer #(
    .W (48)
  ) u_clean (
    .clk_i  (MCLK_I),
    .rstn_i (RSTN_I),
    .load_i (state_q != frst_pkg::ST_RUN),
    .val_i  (48'(CLEAN_RUN_CYC)),
    .en_i   (1'b1),
    .done_o (clean_done)
  );

  // Ramp target: reference clipped to maximum, zero when stopping
  always_comb
  begin
    if (state_q != frst_pkg::ST_RUN || !RUN_CMD_I)
      target = 16'h0000;
    else if (cfg_q.freq_ref > cfg_q.maximum_frequency_setting)
      target = cfg_q.maximum_frequency_setting;
    else
      target = cfg_q.freq_ref;
  end

  // Trip drops output at once; search result seeds the ramp
  assign ramp_load     = TRIP_I || (state_q == frst_pkg::ST_SEARCH && SEARCH_DONE_I);
  assign ramp_load_val = TRIP_I ? 16'h0000 : SEARCH_FREQ_I;

  frst_ramp u_ramp (
    .clk_i      (MCLK_I),
    .rstn_i     (RSTN_I),
    .delta_i    (cfg_q.ramp_reference_select),
    .maxf_i     (cfg_q.maximum_frequency_setting),
    .acc_cyc_i  (acc_cyc),
    .dec_cyc_i  (dec_cyc),
    .target_i   (target),
    .load_i     (ramp_load),
    .load_val_i (ramp_load_val),
    .freq_o     (ramp_freq)
  );

  assign FREQ_O = ramp_freq;

  // Status outputs
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      RUN_O          <= 1'b0;
      SPEED_SEARCH_O <= 1'b0;
    end
    else
    begin
      RUN_O          <= state_q == frst_pkg::ST_RUN;
      SPEED_SEARCH_O <= state_q == frst_pkg::ST_SEARCH;
    end
  end

  // Checks
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RSTN_I);

  a_no_restart_off: assert property (
    state_q == frst_pkg::ST_TRIP && TRIP_RESET_I && !TRIP_I
      && !cfg_q.restart_after_reset_enable |=> state_q == frst_pkg::ST_IDLE)
    else $error("Restart taken while disabled");
  a_delay_holds: assert property (
    state_q == frst_pkg::ST_DELAY && !dly_done && !TRIP_I |=> state_q == frst_pkg::ST_DELAY)
    else $error("Delay left before timer expired");
  a_retry_dec: assert property (
    dly_exit && RUN_CMD_I && !(wr_go && AVS_ADDRESS_I == frst_pkg::OFS_RETRY)
      && retry_left_q != 4'h0 |=> retry_left_q == $past(retry_left_q) - 4'h1)
    else $error("Retry counter not decremented");
  a_zero_no_retry: assert property (
    state_q == frst_pkg::ST_TRIP && retry_left_q == 4'h0 |=> state_q != frst_pkg::ST_DELAY)
    else $error("Restart with empty budget");
  a_single_restart: assert property (
    state_q != frst_pkg::ST_TRIP && state_q != frst_pkg::ST_DELAY
      |=> state_q != frst_pkg::ST_DELAY)
    else $error("Second restart without trip");
  a_retry_reload: assert property (
    state_q == frst_pkg::ST_RUN && clean_done && !dly_exit && !wr_go
      |=> retry_left_q == $past(cfg_q.retry_count_setting))
    else $error("Retry budget not restored");
  a_source_gate: assert property (
    !src_term |=> state_q != frst_pkg::ST_DELAY || $past(state_q) == frst_pkg::ST_DELAY)
    else $error("Restart outside terminal mode");
  a_search_start: assert property (
    dly_exit && RUN_CMD_I && cfg_q.speed_search_options[frst_pkg::SS_RESTART_BIT]
      |=> state_q == frst_pkg::ST_SEARCH ##1 SPEED_SEARCH_O)
    else $error("Speed search not started");
  a_plain_start: assert property (
    dly_exit && RUN_CMD_I && !cfg_q.speed_search_options[frst_pkg::SS_RESTART_BIT]
      |=> state_q == frst_pkg::ST_RUN && ramp_freq == 16'h0000)
    else $error("Plain restart not from zero");
  a_need_edge: assert property (
    state_q == frst_pkg::ST_IDLE && !run_rise && !TRIP_I |=> state_q == frst_pkg::ST_IDLE)
    else $error("Run started without command edge");
  a_trip_zero: assert property (
    TRIP_I |=> ramp_freq == 16'h0000 && state_q == frst_pkg::ST_TRIP)
    else $error("Output not cut on trip");

  c_auto_restart: cover property (dly_exit && RUN_CMD_I);
  c_search_done:  cover property (state_q == frst_pkg::ST_SEARCH && SEARCH_DONE_I);
  c_budget_back:  cover property (state_q == frst_pkg::ST_RUN && clean_done);
  c_ramp_top:     cover property (RUN_O && FREQ_O == cfg_q.maximum_frequency_setting);
endmodule

/* frst_term.sv */
`timescale 1ns/100ps
module frst_term #(
  parameter int unsigned LAT = 3
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        run_req_i,
  input  wire logic        trip_req_i,
  input  wire logic        clr_req_i,
  input  wire logic [15:0] found_i,
  input  wire logic        search_i,
  output logic             run_cmd_o,
  output logic             trip_o,
  output logic             trip_reset_o,
  output logic             search_done_o,
  output logic      [15:0] search_freq_o
);
  logic [3:0] wait_q;
  // Terminal levels follow the bench one edge later; run must drop and rise
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      run_cmd_o    <= 1'b0;
      trip_o       <= 1'b0;
      trip_reset_o <= 1'b0;
    end
    else
    begin
      run_cmd_o    <= run_req_i;
      trip_o       <= trip_req_i;
      trip_reset_o <= clr_req_i;
    end
  end
  // Search answer LAT+1 cycles after search rises; frequency toggles while not valid
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wait_q        <= 4'h0;
      search_done_o <= 1'b0;
      search_freq_o <= 16'h0000;
    end
    else
    begin
      search_done_o <= search_i && (wait_q == 4'(LAT));
      wait_q        <= (search_i && wait_q != 4'(LAT)) ? wait_q + 4'h1 : 4'h0;
      search_freq_o <= (search_i && wait_q == 4'(LAT)) ? found_i : ~search_freq_o;
    end
  end
endmodule

/* testbench.sv */
`timescale 1ns/100ps
module testbench;
  logic clk = 0, rstn = 0, rq = 0, wq = 0, run = 0, trp = 0, clr = 0, ss = 0;
  logic [4:0] adr = 5'h00;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [15:0] frq;
  logic wt, run_o, srch, rc, tr, trr, sd;
  logic [15:0] sf;
  logic [3:0] be = 4'hf;
  logic [15:0] fnd = 16'h0006;
  int err_total = 0, num_checks = 0, n;
  logic [31:0] rv [5] = '{32'h22, 32'h000a0000, 32'hc8, 32'h12c, 32'h1770};
  // Clock and search watcher
  always #10 clk = ~clk;
  always @(posedge clk) ss <= ss | srch;
  frst_ctrl #(.UNIT0_CYC(4), .UNIT1_CYC(8), .UNIT2_CYC(16), .CLEAN_RUN_CYC(64)) dut (
    .MCLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(adr), .AVS_READ_I(rq), .AVS_WRITE_I(wq),
    .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wt), .RUN_CMD_I(rc), .TRIP_I(tr), .TRIP_RESET_I(trr),
    .SEARCH_DONE_I(sd), .SEARCH_FREQ_I(sf), .RUN_O(run_o), .SPEED_SEARCH_O(srch), .FREQ_O(frq));
  frst_term #(.LAT(3)) term (.clk_i(clk), .rstn_i(rstn), .run_req_i(run), .trip_req_i(trp),
    .clr_req_i(clr), .found_i(fnd), .search_i(srch), .run_cmd_o(rc), .trip_o(tr),
    .trip_reset_o(trr), .search_done_o(sd), .search_freq_o(sf));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wq  <= w;
    rq  <= ~w;
    @(negedge clk);
    while (wt !== 1'b0) @(negedge clk);
    @(posedge clk);
    v = rdat;
    wq <= 1'b0;
    rq <= 1'b0;
  endtask
  task automatic st(input string s, input logic [2:0] e, input logic [3:0] l);
    xfer(0, 5'h18, 0);
    chk(s, {e, l}, {v[2:0], v[7:4]});
  endtask
  function automatic logic [31:0] ctl(logic rs, logic [2:0] sr, logic dl, logic [1:0] ts,
                                      logic [7:0] so);
    return {16'h0, so, 1'b0, ts, dl, sr, rs};
  endfunction
  task automatic cnt_until(input logic [15:0] f);
    n = 0;
    while (frq !== f && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic trip_clr;
    @(posedge clk) trp <= 1'b1;
    @(posedge clk) trp <= 1'b0;
    repeat (3) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk) clr <= 1'b0;
    n = 0;
    while (run_o !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic start;
    @(posedge clk) run <= 1'b0;
    repeat (2) @(posedge clk);
    run <= 1'b1;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #400000;
    err_total++;
    complete_run();
  end
  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      xfer(0, 5'(i * 4), 0);
      chk("reset value", rv[i], v);
    end
    xfer(0, 5'h1c, 0);
    chk("unmapped", 0, v);
    be <= 4'h1;
    xfer(1, 5'h14, 32'h1234);
    be <= 4'hf;
    xfer(0, 5'h14, 0);
    chk("byte lane", 32'h34, v);
    $display("test reset done");
    xfer(1, 5'h10, 16);
    xfer(1, 5'h08, 4);
    xfer(1, 5'h0c, 4);
    xfer(1, 5'h14, 8);
    xfer(1, 5'h00, ctl(0, 1, 0, 0, 0));
    start();
    cnt_until(8);
    chk("half ramp", 1, n >= 11 && n <= 13);
    repeat (20) @(posedge clk);
    chk("saturate", 8, frq);
    xfer(1, 5'h00, ctl(0, 1, 1, 0, 0));
    xfer(1, 5'h14, 16);
    cnt_until(16);
    chk("delta ramp", 1, n >= 12 && n <= 18);
    xfer(1, 5'h00, ctl(0, 1, 0, 0, 0));
    xfer(1, 5'h14, 8);
    cnt_until(8);
    chk("max decel", 1, n >= 9 && n <= 11);
    $display("test ramp done");
    trip_clr();
    chk("no restart", 0, run_o);
    st("idle", 0, 0);
    start();
    repeat (6) @(posedge clk);
    chk("run again", 1, run_o);
    xfer(1, 5'h04, {16'h3, 16'h2});
    xfer(1, 5'h00, ctl(1, 1, 0, 0, 0));
    trip_clr();
    chk("delay", 1, n >= 12 && n <= 18);
    chk("from zero", 1, frq <= 2);
    st("left one", 1, 1);
    xfer(1, 5'h00, ctl(1, 2, 0, 1, 0));
    trip_clr();
    chk("scaled delay", 1, n >= 21 && n <= 30);
    st("left zero", 1, 0);
    trip_clr();
    chk("budget out", 200, n);
    st("out idle", 0, 0);
    start();
    repeat (90) @(posedge clk);
    st("reload", 1, 2);
    xfer(1, 5'h00, ctl(1, 0, 0, 1, 0));
    trip_clr();
    chk("source zero", 200, n);
    xfer(1, 5'h00, ctl(1, 1, 0, 2, 8'h04));
    xfer(0, 5'h08, 0);
    chk("raw kept", 4, v);
    start();
    repeat (20) @(posedge clk);
    chk("search idle", 0, ss);
    trip_clr();
    chk("second delay", 1, n >= 57 && n <= 59);
    chk("search seen", 1, ss);
    chk("search freq", 1, frq >= 6 && frq <= 8);
    $display("test restart done");
    complete_run();
  end
endmodule
